// File: include/pcn_pkg.sv
// constants, codes and types of the congestion notifier
// assumes a 100 MHz clock and a two-octet link-layer address
package pcn_pkg;
  // ----------------------------------------------------------
  // congestion levels
  // ----------------------------------------------------------
  localparam logic [1:0] LVL_NORMAL = 2'h0;
  localparam logic [1:0] LVL_MODERATE = 2'h1;
  localparam logic [1:0] LVL_MAXIMUM = 2'h2;

  // ----------------------------------------------------------
  // traffic classes
  // ----------------------------------------------------------
  localparam int CLS_A = 0; // administrative
  localparam int CLS_B = 1; // loss sensitive, delay tolerant
  localparam int CLS_C = 2; // loss and jitter sensitive
  localparam int CLS_D = 3; // loss tolerant, jitter sensitive
  localparam int CLS_E = 4; // loss and delay tolerant
  localparam int CLS_N = 5;

  // ----------------------------------------------------------
  // identifier table and message split
  // ----------------------------------------------------------
  localparam int ID_W = 10; // identifier of a two-octet address
  localparam int ADDR_W = 6;
  localparam int ID_DEPTH = 64;
  localparam int CNT_W = 7;
  localparam int BEAT_W = 3;
  localparam logic [BEAT_W-1:0] MSG_IDS_LAST = 3'h7; // eight ids a message

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLOCK_HZ = 100_000_000;
  localparam int UPDATE_INTERVAL_S = 10; // least update interval
  localparam int UPDATE_CYCLES = UPDATE_INTERVAL_S * CLOCK_HZ;
  localparam int TIMER_W = 32;

  // ----------------------------------------------------------
  // message kinds and sequencer states
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    MSG_NONE = 3'h0,
    MSG_INCREASING = 3'h1,
    MSG_CLEARING = 3'h2,
    MSG_SUSTAINED = 3'h3,
    MSG_CRITICAL = 3'h4,
    MSG_ABATING = 3'h5,
    MSG_CRIT_CLEARING = 3'h6
  } pcn_msg_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } pcn_state_t;
endpackage

// File: design/pcn_congestion_notifier.sv
// congestion level tracking, notification messages and traffic actions
// assumes measurement, table and frame inputs come from logic on clock
`timescale 1ns/1ps

// How it works
// - level is normal, moderate or maximum
// - normal to normal sends nothing
// - leaving normal sends message, then periodic updates
// - update interval at least ten seconds
// - periodic updates stop back at normal
// - normal to moderate sends increasing
// - moderate to normal sends clearing
// - unchanged congested level sends sustained
// - rise into maximum sends critical
// - maximum to moderate sends abating
// - maximum to normal sends critical clearing
// - report every bound circuit identifier
// - list active and idle circuits alike
// - split long lists over several messages
// - discardable frames may drop while congested
// - administrative traffic gets notification only
// - class B drops discardable when persisting
// - class C congestion blocks new calls
// - class D lowers rate, persisting blocks calls
// - forward alarm flag for conditioned channels
// - class E drops discardable when persisting
// - class D trims blocks when delay late
// - peers share two-octet address size
module pcn_congestion_notifier #(
  parameter int UPDATE_CYCLES = pcn_pkg::UPDATE_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic measureStrobe,
  input wire logic [1:0] measuredLevel,
  input wire logic idWrite,
  input wire logic [pcn_pkg::ADDR_W-1:0] idWrAddr,
  input wire logic [pcn_pkg::ID_W-1:0] idWrData,
  input wire logic [pcn_pkg::CNT_W-1:0] idCount,
  input wire logic [pcn_pkg::CLS_N-1:0] classPresent,
  input wire logic trunkConditioned,
  input wire logic msgReady,
  input wire logic frameValid,
  input wire logic [2:0] frameClass,
  input wire logic frameDiscardable,
  input wire logic frameEmbedded,
  input wire logic frameDelayLate,
  output logic [1:0] congestionLevel,
  output logic msgValid,
  output pcn_pkg::pcn_msg_t msgType,
  output logic [pcn_pkg::ID_W-1:0] msgId,
  output logic msgFirst,
  output logic msgLast,
  output logic callBlock,
  output logic rateReduce,
  output logic forwardAlarm,
  output logic frameDone,
  output logic frameDrop,
  output logic frameTrim
);
  // ----------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------
  // message kind from previous and new level
  function automatic pcn_pkg::pcn_msg_t msg_kind(input logic [1:0] prev, input logic [1:0] now);
    pcn_pkg::pcn_msg_t k;
    k = pcn_pkg::MSG_NONE;
    if (prev == pcn_pkg::LVL_NORMAL && now == pcn_pkg::LVL_MODERATE) k = pcn_pkg::MSG_INCREASING;
    if (prev == pcn_pkg::LVL_MODERATE && now == pcn_pkg::LVL_NORMAL) k = pcn_pkg::MSG_CLEARING;
    if (prev != pcn_pkg::LVL_MAXIMUM && now == pcn_pkg::LVL_MAXIMUM) k = pcn_pkg::MSG_CRITICAL;
    if (prev == pcn_pkg::LVL_MAXIMUM && now == pcn_pkg::LVL_MODERATE) k = pcn_pkg::MSG_ABATING;
    if (prev == pcn_pkg::LVL_MAXIMUM && now == pcn_pkg::LVL_NORMAL) k = pcn_pkg::MSG_CRIT_CLEARING;
    return k;
  endfunction

  // last identifier of a message: beat full or list done
  function automatic logic beat_last(input logic [pcn_pkg::CNT_W-1:0] i, input logic [pcn_pkg::BEAT_W-1:0] b,
                                     input logic [pcn_pkg::CNT_W-1:0] n);
    return (b == pcn_pkg::MSG_IDS_LAST) || (pcn_pkg::CNT_W'(i + 1'b1) >= n);
  endfunction

  // ----------------------------------------------------------
  // identifier table
  // ----------------------------------------------------------
  logic [pcn_pkg::ID_W-1:0] idTable [pcn_pkg::ID_DEPTH];

  // table write, no reset needed for storage
  always_ff @(posedge clock) begin
    if (idWrite) begin
      idTable[idWrAddr] <= idWrData;
    end
  end

  // ----------------------------------------------------------
  // level, timer and message sequencer
  // ----------------------------------------------------------
  logic [1:0] level;
  logic persist;
  logic [pcn_pkg::TIMER_W-1:0] timer;
  logic pending;
  pcn_pkg::pcn_msg_t pendType;
  pcn_pkg::pcn_state_t state;
  logic [pcn_pkg::CNT_W-1:0] idx;
  logic [pcn_pkg::BEAT_W-1:0] beat;
  logic [1:0] next_level;
  logic next_persist;
  logic [pcn_pkg::TIMER_W-1:0] next_timer;
  logic next_pending;
  pcn_pkg::pcn_msg_t next_pendType;
  pcn_pkg::pcn_state_t next_state;
  logic [pcn_pkg::CNT_W-1:0] next_idx;
  logic [pcn_pkg::BEAT_W-1:0] next_beat;
  logic next_msgValid;
  pcn_pkg::pcn_msg_t next_msgType;
  logic [pcn_pkg::ID_W-1:0] next_msgId;
  logic next_msgFirst;
  logic next_msgLast;
  logic [pcn_pkg::CNT_W-1:0] nextIdx;
  logic timerHit;
  pcn_pkg::pcn_msg_t kind;

  // next level, timer, queue and message beat
  always_comb begin
    next_level = level;
    next_persist = persist;
    next_timer = timer;
    next_pending = pending;
    next_pendType = pendType;
    next_state = state;
    next_idx = idx;
    next_beat = beat;
    next_msgValid = msgValid;
    next_msgType = msgType;
    next_msgId = msgId;
    next_msgFirst = msgFirst;
    next_msgLast = msgLast;
    nextIdx = pcn_pkg::CNT_W'(idx + 1'b1);
    timerHit = (timer == pcn_pkg::TIMER_W'(UPDATE_CYCLES - 1));
    kind = pcn_pkg::MSG_NONE;
    // sequencer first, so a new request in this cycle wins over the clear
    case (state)
      pcn_pkg::ST_IDLE: begin
        if (pending) begin
          next_pending = 1'b0;
          next_state = pcn_pkg::ST_SEND;
          next_msgValid = 1'b1;
          next_msgType = pendType;
          next_idx = '0;
          next_beat = '0;
          next_msgId = idTable[0];
          next_msgFirst = 1'b1;
          next_msgLast = beat_last('0, '0, idCount);
        end
      end
      pcn_pkg::ST_SEND: begin
        if (msgReady) begin
          if (msgLast && nextIdx >= idCount) begin
            next_state = pcn_pkg::ST_IDLE; // whole list sent
            next_msgValid = 1'b0;
            next_msgFirst = 1'b0;
            next_msgLast = 1'b0;
          end else begin
            next_idx = nextIdx;
            next_beat = msgLast ? '0 : pcn_pkg::BEAT_W'(beat + 1'b1);
            next_msgId = idTable[nextIdx[pcn_pkg::ADDR_W-1:0]];
            next_msgFirst = msgLast;
            next_msgLast = beat_last(nextIdx, msgLast ? '0 : pcn_pkg::BEAT_W'(beat + 1'b1), idCount);
          end
        end
      end
      default: begin
        next_state = pcn_pkg::ST_IDLE;
        next_msgValid = 1'b0;
      end
    endcase
    // periodic update runs only while congested
    if (level == pcn_pkg::LVL_NORMAL) begin
      next_timer = '0;
    end else if (timerHit) begin
      next_timer = '0;
      next_pending = 1'b1;
      next_pendType = pcn_pkg::MSG_SUSTAINED;
      next_persist = 1'b1;
    end else begin
      next_timer = pcn_pkg::TIMER_W'(timer + 1'b1);
    end
    // measurement: latch level, queue transition message
    if (measureStrobe) begin
      next_level = (measuredLevel == pcn_pkg::LVL_NORMAL) ? pcn_pkg::LVL_NORMAL :
                   (measuredLevel == pcn_pkg::LVL_MODERATE) ? pcn_pkg::LVL_MODERATE :
                   pcn_pkg::LVL_MAXIMUM;
      kind = msg_kind(level, next_level);
      if (kind != pcn_pkg::MSG_NONE) begin
        next_pending = 1'b1;
        next_pendType = kind;
        next_timer = '0;
      end
      if (next_level == pcn_pkg::LVL_NORMAL) begin
        next_persist = 1'b0;
        next_timer = '0;
      end
    end
  end

  // level, timer and sequencer registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      level <= pcn_pkg::LVL_NORMAL;
      persist <= 1'b0;
      timer <= '0;
      pending <= 1'b0;
      pendType <= pcn_pkg::MSG_NONE;
      state <= pcn_pkg::ST_IDLE;
      idx <= '0;
      beat <= '0;
      msgValid <= 1'b0;
      msgType <= pcn_pkg::MSG_NONE;
      msgId <= '0;
      msgFirst <= 1'b0;
      msgLast <= 1'b0;
    end else begin
      level <= next_level;
      persist <= next_persist;
      timer <= next_timer;
      pending <= next_pending;
      pendType <= next_pendType;
      state <= next_state;
      idx <= next_idx;
      beat <= next_beat;
      msgValid <= next_msgValid;
      msgType <= next_msgType;
      msgId <= next_msgId;
      msgFirst <= next_msgFirst;
      msgLast <= next_msgLast;
    end
  end

  // ----------------------------------------------------------
  // traffic actions
  // ----------------------------------------------------------
  logic next_callBlock;
  logic next_rateReduce;
  logic next_forwardAlarm;
  logic next_frameDrop;
  logic next_frameTrim;
  logic congested;
  logic dropClass;

  // per-class reaction to the current level
  always_comb begin
    congested = (level != pcn_pkg::LVL_NORMAL);
    // class A never listed here: notification only
    dropClass = (frameClass == 3'(pcn_pkg::CLS_B)) || (frameClass == 3'(pcn_pkg::CLS_E));
    next_callBlock = congested && (classPresent[pcn_pkg::CLS_C] || (classPresent[pcn_pkg::CLS_D] && persist));
    next_rateReduce = congested && classPresent[pcn_pkg::CLS_D];
    next_forwardAlarm = congested && trunkConditioned;
    next_frameDrop = frameValid && frameDiscardable && persist && dropClass;
    next_frameTrim = frameValid && congested && frameEmbedded && frameDelayLate &&
                     (frameClass == 3'(pcn_pkg::CLS_D));
  end

  // action registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      congestionLevel <= pcn_pkg::LVL_NORMAL;
      callBlock <= 1'b0;
      rateReduce <= 1'b0;
      forwardAlarm <= 1'b0;
      frameDone <= 1'b0;
      frameDrop <= 1'b0;
      frameTrim <= 1'b0;
    end else begin
      congestionLevel <= next_level;
      callBlock <= next_callBlock;
      rateReduce <= next_rateReduce;
      forwardAlarm <= next_forwardAlarm;
      frameDone <= frameValid;
      frameDrop <= next_frameDrop;
      frameTrim <= next_frameTrim;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_level_legal: assert property (level != 2'h3 && congestionLevel == level)
    else $error("illegal congestion level");
  a_normal_quiet: assert property (
    measureStrobe && level == pcn_pkg::LVL_NORMAL && measuredLevel == pcn_pkg::LVL_NORMAL && !pending
    && state == pcn_pkg::ST_IDLE |=> !pending && !msgValid)
    else $error("message queued while normal");
  a_increase_msg: assert property (
    measureStrobe && level == pcn_pkg::LVL_NORMAL && measuredLevel == pcn_pkg::LVL_MODERATE
    |=> pending && pendType == pcn_pkg::MSG_INCREASING)
    else $error("increasing message missing");
  a_critical_msg: assert property (
    measureStrobe && level != pcn_pkg::LVL_MAXIMUM && measuredLevel == pcn_pkg::LVL_MAXIMUM
    |=> pending && pendType == pcn_pkg::MSG_CRITICAL)
    else $error("critical message missing");
  a_crit_clear: assert property (
    measureStrobe && level == pcn_pkg::LVL_MAXIMUM && measuredLevel == pcn_pkg::LVL_NORMAL
    |=> pendType == pcn_pkg::MSG_CRIT_CLEARING)
    else $error("critical clearing message missing");
  a_sustained_tick: assert property (
    level != pcn_pkg::LVL_NORMAL && timer == UPDATE_CYCLES - 1 && !measureStrobe
    |=> pending && pendType == pcn_pkg::MSG_SUSTAINED && timer == 0)
    else $error("periodic update missing");
  a_timer_bound: assert property (timer < UPDATE_CYCLES && (level != pcn_pkg::LVL_NORMAL || timer == 0))
    else $error("update timer out of range");
  a_stop_normal: assert property (
    level == pcn_pkg::LVL_NORMAL && !measureStrobe |=> !(pending && pendType == pcn_pkg::MSG_SUSTAINED
    && !$past(pending)))
    else $error("periodic update while normal");
  a_split_list: assert property (
    msgValid && msgReady && !msgLast |=> msgValid && !msgFirst && idx == $past(idx) + 1)
    else $error("message list broken");
  a_block_cong: assert property (callBlock |-> $past(level) != pcn_pkg::LVL_NORMAL)
    else $error("calls blocked while normal");

  c_increase: cover property (msgValid && msgFirst && msgType == pcn_pkg::MSG_INCREASING);
  c_sustained: cover property (msgValid && msgFirst && msgType == pcn_pkg::MSG_SUSTAINED);
  c_split: cover property (msgValid && msgReady && msgLast ##1 msgValid && msgFirst);
  c_drop: cover property (frameDrop);
endmodule

// File: bench/pcn_msg_sink.sv
// peer node model that takes notification message beats
// assumes the notifier's clock and active-low reset
`timescale 1ns/1ps

// ----------------------------------------------------------
// message sink
// ----------------------------------------------------------
module pcn_msg_sink (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic stall,
  input wire logic msgValid,
  output logic msgReady
);
  // ready every cycle, or every other cycle of a standing beat while stalling
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      msgReady <= 1'b0;
    end else begin
      msgReady <= stall ? (msgValid && !msgReady) : 1'b1;
    end
  end
endmodule

// File: bench/pcn_congestion_notifier_tb.sv
// self-checking bench of the congestion notifier
// assumes the package on the include path and a short update interval
`timescale 1ns/1ps

module pcn_congestion_notifier_tb;
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  localparam int UPD = 50;
  typedef struct {
    logic [1:0] lvl;
    logic [1:0] expLvl;
    pcn_pkg::pcn_msg_t typ;
  } pcn_row_t;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic measureStrobe = 1'b0;
  logic [1:0] measuredLevel = 2'h0;
  logic idWrite = 1'b0;
  logic [5:0] idWrAddr = 6'h00;
  logic [9:0] idWrData = 10'h000;
  logic [6:0] idCount = 7'h0a;
  logic [4:0] classPresent = 5'h1f;
  logic trunkConditioned = 1'b1;
  logic frameValid = 1'b0;
  logic [2:0] frameClass = 3'h0;
  logic frameDiscardable = 1'b0;
  logic frameEmbedded = 1'b0;
  logic frameDelayLate = 1'b0;
  logic stall = 1'b0;
  logic msgReady;
  logic [1:0] congestionLevel;
  logic msgValid;
  pcn_pkg::pcn_msg_t msgType;
  logic [9:0] msgId;
  logic msgFirst;
  logic msgLast;
  logic callBlock;
  logic rateReduce;
  logic forwardAlarm;
  logic frameDone;
  logic frameDrop;
  logic frameTrim;
  int err_total = 0;
  int checked = 0;
  int i;
  pcn_row_t rows [6] = '{
    '{2'h1, 2'h1, pcn_pkg::MSG_INCREASING}, '{2'h0, 2'h0, pcn_pkg::MSG_CLEARING},
    '{2'h2, 2'h2, pcn_pkg::MSG_CRITICAL}, '{2'h1, 2'h1, pcn_pkg::MSG_ABATING},
    '{2'h3, 2'h2, pcn_pkg::MSG_CRITICAL}, '{2'h0, 2'h0, pcn_pkg::MSG_CRIT_CLEARING}};

  pcn_congestion_notifier #(.UPDATE_CYCLES(UPD)) uut (
    .clock(clock), .reset_n(reset_n), .measureStrobe(measureStrobe), .measuredLevel(measuredLevel),
    .idWrite(idWrite), .idWrAddr(idWrAddr), .idWrData(idWrData), .idCount(idCount),
    .classPresent(classPresent), .trunkConditioned(trunkConditioned), .msgReady(msgReady),
    .frameValid(frameValid), .frameClass(frameClass), .frameDiscardable(frameDiscardable),
    .frameEmbedded(frameEmbedded), .frameDelayLate(frameDelayLate), .congestionLevel(congestionLevel),
    .msgValid(msgValid), .msgType(msgType), .msgId(msgId), .msgFirst(msgFirst), .msgLast(msgLast),
    .callBlock(callBlock), .rateReduce(rateReduce), .forwardAlarm(forwardAlarm), .frameDone(frameDone),
    .frameDrop(frameDrop), .frameTrim(frameTrim));

  pcn_msg_sink sink (.clock(clock), .reset_n(reset_n), .stall(stall), .msgValid(msgValid), .msgReady(msgReady));

  // clock generator
  always #5 clock = ~clock;

  // ----------------------------------------------------------
  // compare, drive and closing tasks
  // ----------------------------------------------------------
  task end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_msg(input pcn_pkg::pcn_msg_t got, input pcn_pkg::pcn_msg_t exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one strobe, then the registered level
  task measure(input logic [1:0] l, input logic [1:0] e);
    @(posedge clock);
    measureStrobe <= 1'b1;
    measuredLevel <= l;
    @(posedge clock);
    measureStrobe <= 1'b0;
    #1 cmp_val(16'(congestionLevel), 16'(e));
  endtask

  // takes a whole identifier list, beat by beat, under a bounded wait
  task recv(input pcn_pkg::pcn_msg_t t, input int n);
    int k;
    for (int b = 0; b < ((n == 0) ? 1 : n); b++) begin
      k = 0;
      while (!(msgValid === 1'b1 && msgReady === 1'b1) && k < 300) begin
        @(posedge clock);
        #1;
        k++;
      end
      if (k >= 300) begin
        err_total++;
        end_sim();
      end
      cmp_msg(msgType, t);
      cmp_val(16'(msgId), 16'h0100 + 16'(b));
      cmp_val({15'h0, msgFirst}, 16'(b % 8 == 0));
      cmp_val({15'h0, msgLast}, 16'(b % 8 == 7 || b == n - 1 || n == 0));
      @(posedge clock);
      #1;
    end
  endtask

  // one frame, then its verdict
  task frame(input int c, input logic d, input logic em, input logic late, input logic eDrop, input logic eTrim);
    @(posedge clock);
    frameValid <= 1'b1;
    frameClass <= 3'(c);
    frameDiscardable <= d;
    frameEmbedded <= em;
    frameDelayLate <= late;
    @(posedge clock);
    frameValid <= 1'b0;
    #1 cmp_val({13'h0, frameDone, frameDrop, frameTrim}, {13'h0, 1'b1, eDrop, eTrim});
  endtask

  // no message may start for n cycles
  task quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      #1 cmp_val({15'h0, msgValid}, 16'h0);
    end
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    #1 cmp_val({12'h0, congestionLevel, msgValid, callBlock}, 16'h0);
    @(posedge clock);
    reset_n <= 1'b1;
    // identifier table 0x100 upward
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      idWrite <= 1'b1;
      idWrAddr <= 6'(i);
      idWrData <= 10'h100 + 10'(i);
    end
    @(posedge clock);
    idWrite <= 1'b0;
    // every transition kind, ten ids split eight and two
    for (i = 0; i < 6; i++) begin
      stall <= 1'(i % 2);
      measure(rows[i].lvl, rows[i].expLvl);
      recv(rows[i].typ, 10);
    end
    // exactly one full message, then the periodic update; only class D carried
    stall <= 1'b0;
    idCount <= 7'h08;
    classPresent <= 5'h08;
    measure(2'h1, 2'h1);
    recv(pcn_pkg::MSG_INCREASING, 8);
    cmp_val({13'h0, callBlock, rateReduce, forwardAlarm}, 16'h3);
    frame(pcn_pkg::CLS_B, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    quiet(39);
    recv(pcn_pkg::MSG_SUSTAINED, 8);
    cmp_val({13'h0, callBlock, rateReduce, forwardAlarm}, 16'h7);
    // class C alone blocks calls with no rate change
    classPresent <= 5'h04;
    @(posedge clock);
    #1 cmp_val({13'h0, callBlock, rateReduce, forwardAlarm}, 16'h5);
    frame(pcn_pkg::CLS_B, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(pcn_pkg::CLS_A, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    frame(pcn_pkg::CLS_E, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(pcn_pkg::CLS_D, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    // forward alarm only for conditioned channels
    trunkConditioned <= 1'b0;
    @(posedge clock);
    #1 cmp_val({15'h0, forwardAlarm}, 16'h0);
    // empty list still gives one beat, then silence at normal
    idCount <= 7'h00;
    measure(2'h0, 2'h0);
    recv(pcn_pkg::MSG_CLEARING, 0);
    cmp_val({13'h0, callBlock, rateReduce, forwardAlarm}, 16'h0);
    frame(pcn_pkg::CLS_B, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    quiet(120);
    measure(2'h0, 2'h0);
    quiet(20);
    // reset in mid-run drops a queued critical message
    trunkConditioned <= 1'b1;
    measure(2'h2, 2'h2);
    reset_n <= 1'b0;
    #1 cmp_val({12'h0, congestionLevel, msgValid, callBlock}, 16'h0);
    @(posedge clock);
    reset_n <= 1'b1;
    quiet(20);
    end_sim();
  end
endmodule
